// ### uhd_map.svh
`ifndef UHD_MAP_SVH
`define UHD_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, 12-bit bus address)
// ----------------------------------------------------------------
`define UHD_CTRL_OFS        12'h000
`define UHD_STATUS_OFS      12'h004
`define UHD_BASE_OFS        12'h008
`define UHD_COUNT_OFS       12'h00c
`define UHD_RAM_SEL_BIT     11
`define UHD_CTRL_START_BIT  0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UHD_BASE_RST        9'h000
`define UHD_COUNT_RST       16'h0000

// ----------------------------------------------------------------
// transfer_header layout, word 0 = bytes 0..3, word 1 = bytes 4..7
// ----------------------------------------------------------------
`define UHD_HDR_WORDS       9'h002
`define UHD_W0_MOVED        9:0
`define UHD_W0_TOGGLE       10
`define UHD_W0_ACTIVE       11
`define UHD_W0_CODE         15:12
`define UHD_W0_LIMIT        25:16
`define UHD_W0_SPEED        26
`define UHD_W0_LAST         27
`define UHD_W0_ENDPOINT     31:28
`define UHD_W1_LENGTH       9:0
`define UHD_W1_PID          11:10
`define UHD_W1_ADDR         22:16
`define UHD_W1_FORMAT       23

// ----------------------------------------------------------------
// direction codes and outcome codes
// ----------------------------------------------------------------
`define UHD_PID_SETUP       2'h0
`define UHD_PID_OUT         2'h1
`define UHD_PID_IN          2'h2
`define UHD_OC_OK           4'h0
`define UHD_OC_CRC          4'h1
`define UHD_OC_STUFF        4'h2
`define UHD_OC_SEQ          4'h3
`define UHD_OC_STALL        4'h4
`define UHD_OC_NO_REPLY     4'h5
`define UHD_OC_PID_CHECK    4'h6
`define UHD_OC_PID_INVALID  4'h7
`define UHD_OC_TOO_MUCH     4'h8
`define UHD_OC_SHORT        4'h9
`define UHD_OC_STORE_SLOW   4'hc
`define UHD_OC_FETCH_SLOW   4'hd

`endif

// ### uhd_pkg.sv
package uhd_pkg;

    typedef enum logic [2:0] {
        UHD_IDLE,
        UHD_HDR0,
        UHD_HDR1,
        UHD_PKT,
        UHD_WAIT,
        UHD_WB,
        UHD_NEXT
    } uhd_state_t;

    typedef logic [3:0] uhd_code_t;

endpackage : uhd_pkg

// ### uhd_ram_if.sv
`timescale 1ns/1ps

interface uhd_ram_if #(parameter int AW = 9);
    logic [AW-1:0] bus_addr;
    logic          bus_we;
    logic [31:0]   bus_wdata;
    logic [31:0]   bus_rdata;
    logic [AW-1:0] eng_addr;
    logic          eng_we;
    logic [31:0]   eng_wdata;
    logic [31:0]   eng_rdata;

    modport user (
        output bus_addr, bus_we, bus_wdata, eng_addr, eng_we, eng_wdata,
        input  bus_rdata, eng_rdata
    );
    modport mem (
        input  bus_addr, bus_we, bus_wdata, eng_addr, eng_we, eng_wdata,
        output bus_rdata, eng_rdata
    );
endinterface : uhd_ram_if

// ### uhd_buffer_ram.sv
`timescale 1ns/1ps

module uhd_buffer_ram #(
    parameter int AW = 9
) (
    input  wire logic pclk,
    uhd_ram_if.mem    ram
);
    logic [31:0] mem [2**AW];

    // engine write-back wins a same-word collision with the bus
    always_ff @(posedge pclk) begin
        if (ram.bus_we && !(ram.eng_we && ram.eng_addr == ram.bus_addr)) begin
            mem[ram.bus_addr] <= ram.bus_wdata;
        end
        if (ram.eng_we) begin
            mem[ram.eng_addr] <= ram.eng_wdata;
        end
    end

    assign ram.bus_rdata = mem[ram.bus_addr];
    assign ram.eng_rdata = mem[ram.eng_addr];

endmodule : uhd_buffer_ram

// ### uhd_host_descriptor.sv
// Contract
// - write a ten-bit count of bytes really moved for the descriptor
// - outcome 0000 when processing ended without detected error
// - outcome 0001 when last received data packet failed CRC
// - outcome 0010 when last received data packet broke bit stuffing
// - outcome 0011 when received data PID differs from expected toggle
// - outcome 0100 and retire descriptor on a STALL handshake
// - outcome 0101 when no reply to IN or no handshake after OUT
// - outcome 0110 when PID check bits fail on data or handshake
// - outcome 0111 when received PID is undefined or out of place
// - outcome 1000 when payload exceeds packet limit or remaining space
// - outcome 1001 when short non-isochronous IN packet leaves the buffer unfilled
// - outcome 1100 when IN data arrives faster than it is stored
// - outcome 1101 when OUT data cannot be fetched in time; 1010/1011 unused
// - run only active descriptors, clear active on completion, skip later
// - toggle bit gives DATA0/DATA1, flips after each good non-isochronous data packet
// - last flag ends the list; traversal stops after it
// - header is eight bytes followed by its payload in buffer RAM
// - format bit 0 is control/bulk/interrupt, 1 is isochronous
`timescale 1ns/1ps
`include "uhd_map.svh"

module uhd_host_descriptor
    import uhd_pkg::*;
#(
    parameter int RAM_AW = 9
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txn_start,
    output logic      [1:0]  txn_pid,
    output logic      [6:0]  txn_addr,
    output logic      [3:0]  txn_endpoint,
    output logic             txn_low_speed,
    output logic             txn_iso,
    output logic             txn_toggle,
    output logic      [9:0]  txn_len,
    input  wire logic        txn_done,
    input  wire logic [9:0]  txn_count,
    input  wire logic        txn_data_pid,
    input  wire logic        txn_no_reply,
    input  wire logic        txn_pid_check_bad,
    input  wire logic        txn_pid_invalid,
    input  wire logic        txn_stall,
    input  wire logic        txn_crc_bad,
    input  wire logic        txn_stuff_bad,
    input  wire logic        txn_store_late,
    input  wire logic        txn_fetch_late,
    output logic             list_busy,
    output logic             header_done
);

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    generate
        if (RAM_AW < 2 || RAM_AW > 9) begin : g_bad_aw
            $error("RAM_AW must lie in 2..9 to fit the bus window");
        end
    endgenerate

    uhd_ram_if #(.AW(RAM_AW)) ram ();

    uhd_buffer_ram #(.AW(RAM_AW)) u_ram (
        .pclk (pclk),
        .ram  (ram)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic              acc_q;
    logic              bus_fire;
    logic              ram_hit;
    logic              reg_hit;
    logic [RAM_AW-1:0] base;
    logic [15:0]       retired;
    uhd_code_t         last_code;
    logic              list_ended;
    uhd_state_t        state;
    logic              start_req;

    // one wait state: read data is captured in the first access cycle, writes take effect in the second
    assign pready   = psel & penable & acc_q;
    assign bus_fire = psel & penable & acc_q;
    assign ram_hit  = paddr[`UHD_RAM_SEL_BIT];
    assign reg_hit  = !ram_hit && (paddr == `UHD_CTRL_OFS || paddr == `UHD_STATUS_OFS
                                   || paddr == `UHD_BASE_OFS || paddr == `UHD_COUNT_OFS);
    assign pslverr  = pready & !ram_hit & !reg_hit;

    assign ram.bus_addr  = paddr[RAM_AW+1:2];
    assign ram.bus_we    = bus_fire & pwrite & ram_hit;
    assign ram.bus_wdata = pwdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= psel & penable & !acc_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !acc_q && !pwrite) begin
            if (ram_hit) begin
                prdata <= ram.bus_rdata;
            end else begin
                case (paddr)
                    `UHD_STATUS_OFS: prdata <= {23'h000000, list_ended, last_code, 3'h0,
                                                (state != UHD_IDLE)};
                    `UHD_BASE_OFS:   prdata <= {{(32-RAM_AW){1'b0}}, base};
                    `UHD_COUNT_OFS:  prdata <= {16'h0000, retired};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base <= RAM_AW'(`UHD_BASE_RST);
        end else if (bus_fire && pwrite && !ram_hit && paddr == `UHD_BASE_OFS) begin
            base <= pwdata[RAM_AW-1:0];
        end
    end

    // start is a self-clearing request; ignored while a walk runs
    assign start_req = bus_fire && pwrite && !ram_hit && paddr == `UHD_CTRL_OFS
                       && pwdata[`UHD_CTRL_START_BIT];

    // ----------------------------------------------------------------
    // descriptor engine
    // ----------------------------------------------------------------
    logic [RAM_AW-1:0] ptr;
    logic [31:0]       w0;
    logic [31:0]       w1;
    logic [9:0]        moved;
    logic              toggle;
    uhd_code_t         code;
    logic [9:0]        req_len;
    logic [9:0]        remain;
    logic              dir_in;
    logic              iso;
    logic [10:0]       moved_sum;
    logic [RAM_AW+8:0] next_ptr_wide;
    uhd_code_t         pkt_code;

    assign dir_in    = (w1[`UHD_W1_PID] == `UHD_PID_IN);
    assign iso       = w1[`UHD_W1_FORMAT];
    assign remain    = w1[`UHD_W1_LENGTH] - moved;
    assign moved_sum = {1'b0, moved} + {1'b0, txn_count};

    // header then payload, rounded to whole words
    assign next_ptr_wide = {9'h000, ptr} + {9'h000, RAM_AW'(`UHD_HDR_WORDS)}
                           + {{(RAM_AW-1){1'b0}}, 10'((11'(w1[`UHD_W1_LENGTH]) + 11'h003) >> 2)};

    // error causes in priority order; a broken token exchange outranks payload checks
    always_comb begin
        pkt_code = `UHD_OC_OK;
        if (txn_no_reply) begin
            pkt_code = `UHD_OC_NO_REPLY;
        end else if (txn_pid_check_bad) begin
            pkt_code = `UHD_OC_PID_CHECK;
        end else if (txn_pid_invalid) begin
            pkt_code = `UHD_OC_PID_INVALID;
        end else if (txn_stall) begin
            pkt_code = `UHD_OC_STALL;
        end else if (dir_in && txn_crc_bad) begin
            pkt_code = `UHD_OC_CRC;
        end else if (dir_in && txn_stuff_bad) begin
            pkt_code = `UHD_OC_STUFF;
        // toggle mismatch, isochronous has no sequence
        end else if (dir_in && !iso && txn_data_pid != toggle) begin
            pkt_code = `UHD_OC_SEQ;
        end else if (dir_in && txn_count > req_len) begin
            pkt_code = `UHD_OC_TOO_MUCH;
        end else if (dir_in && txn_store_late) begin
            pkt_code = `UHD_OC_STORE_SLOW;
        end else if (!dir_in && txn_fetch_late) begin
            pkt_code = `UHD_OC_FETCH_SLOW;
        end
    end

    assign ram.eng_addr  = (state == UHD_HDR1) ? ptr + RAM_AW'(1) : ptr;
    assign ram.eng_we    = (state == UHD_WB);
    assign ram.eng_wdata = {w0[`UHD_W0_ENDPOINT], w0[`UHD_W0_LAST], w0[`UHD_W0_SPEED],
                            w0[`UHD_W0_LIMIT], code, 1'b0, toggle, moved};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= UHD_IDLE;
        end else begin
            case (state)
                UHD_IDLE: begin
                    if (start_req) begin
                        state <= UHD_HDR0;
                    end
                end
                UHD_HDR0: begin
                    state <= UHD_HDR1;
                end
                UHD_HDR1: begin
                    if (!w0[`UHD_W0_ACTIVE]) begin
                        state <= UHD_NEXT;
                    end else if (ram.eng_rdata[`UHD_W1_PID] == 2'h3) begin
                        state <= UHD_WB;
                    end else begin
                        state <= UHD_PKT;
                    end
                end
                UHD_PKT: begin
                    state <= UHD_WAIT;
                end
                UHD_WAIT: begin
                    if (txn_done) begin
                        if (pkt_code != `UHD_OC_OK || iso || moved_sum >= {1'b0, w1[`UHD_W1_LENGTH]}
                            || (dir_in && txn_count < req_len)) begin
                            state <= UHD_WB;
                        end else begin
                            state <= UHD_PKT;
                        end
                    end
                end
                UHD_WB: begin
                    state <= UHD_NEXT;
                end
                UHD_NEXT: begin
                    if (w0[`UHD_W0_LAST] || next_ptr_wide > (RAM_AW+9)'(2**RAM_AW - 2)) begin
                        state <= UHD_IDLE;
                    end else begin
                        state <= UHD_HDR0;
                    end
                end
                default: begin
                    state <= UHD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr <= '0;
        end else if (state == UHD_IDLE && start_req) begin
            ptr <= base;
        end else if (state == UHD_NEXT) begin
            ptr <= next_ptr_wide[RAM_AW-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w0 <= 32'h0000_0000;
            w1 <= 32'h0000_0000;
        end else if (state == UHD_HDR0) begin
            w0 <= ram.eng_rdata;
        end else if (state == UHD_HDR1) begin
            w1 <= ram.eng_rdata;
        end
    end

    // per-descriptor progress: count, toggle and outcome
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            moved  <= 10'h000;
            toggle <= 1'b0;
            code   <= `UHD_OC_OK;
        end else if (state == UHD_HDR1) begin
            moved  <= 10'h000;
            toggle <= w0[`UHD_W0_TOGGLE];
            // reserved direction code is refused as an unexpected pid
            code   <= (ram.eng_rdata[`UHD_W1_PID] == 2'h3) ? `UHD_OC_PID_INVALID : `UHD_OC_OK;
        end else if (state == UHD_WAIT && txn_done) begin
            code <= pkt_code;
            if (pkt_code == `UHD_OC_OK) begin
                moved <= moved_sum[9:0];
                if (!iso) begin
                    toggle <= ~toggle;
                end
                if (dir_in && !iso && txn_count < req_len
                    && moved_sum < {1'b0, w1[`UHD_W1_LENGTH]}) begin
                    code <= `UHD_OC_SHORT;
                end else begin
                    code <= `UHD_OC_OK;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // transaction request
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn_start     <= 1'b0;
            txn_pid       <= 2'h0;
            txn_addr      <= 7'h00;
            txn_endpoint  <= 4'h0;
            txn_low_speed <= 1'b0;
            txn_iso       <= 1'b0;
            txn_toggle    <= 1'b0;
            txn_len       <= 10'h000;
            req_len       <= 10'h000;
        end else begin
            txn_start <= (state == UHD_PKT);
            if (state == UHD_PKT) begin
                txn_pid       <= w1[`UHD_W1_PID];
                txn_addr      <= w1[`UHD_W1_ADDR];
                txn_endpoint  <= w0[`UHD_W0_ENDPOINT];
                txn_low_speed <= w0[`UHD_W0_SPEED];
                txn_iso       <= iso;
                txn_toggle    <= toggle;
                if (remain > w0[`UHD_W0_LIMIT]) begin
                    txn_len <= w0[`UHD_W0_LIMIT];
                    req_len <= w0[`UHD_W0_LIMIT];
                end else begin
                    txn_len <= remain;
                    req_len <= remain;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retired     <= `UHD_COUNT_RST;
            last_code   <= `UHD_OC_OK;
            header_done <= 1'b0;
        end else begin
            // completion signalled only after the header word is stored
            header_done <= (state == UHD_WB);
            if (state == UHD_WB) begin
                retired   <= retired + 16'h0001;
                last_code <= code;
            end else if (bus_fire && pwrite && !ram_hit && paddr == `UHD_COUNT_OFS) begin
                retired <= `UHD_COUNT_RST;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            list_ended <= 1'b0;
        end else if (state == UHD_IDLE && start_req) begin
            list_ended <= 1'b0;
        end else if (state == UHD_NEXT && w0[`UHD_W0_LAST]) begin
            list_ended <= 1'b1;
        end
    end

    assign list_busy = (state != UHD_IDLE);

endmodule : uhd_host_descriptor

// ### uhd_host_descriptor_asserts.sv
`timescale 1ns/1ps
module uhd_host_descriptor_asserts (
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pready,
    input logic       pslverr,
    input logic       txn_start,
    input logic       txn_done,
    input logic [1:0] txn_pid,
    input logic [9:0] txn_len,
    input logic       txn_toggle,
    input logic       list_busy,
    input logic       header_done
);
    // ----------------------------------------
    // helper: one transaction outstanding
    // ----------------------------------------
    logic wt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wt <= 1'b0;
        else if (txn_start)
            wt <= 1'b1;
        else if (txn_done)
            wt <= 1'b0;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_acc; psel && penable; endsequence
    sequence s_reply; wt && txn_done; endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_one_wait: assert property (s_setup ##1 s_acc |-> !pready ##1 pready)
        else $error("access not one wait state");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_start_pulse: assert property (txn_start |=> !txn_start)
        else $error("start longer than a cycle");
    a_start_in_walk: assert property (txn_start |-> list_busy)
        else $error("start outside walk");
    a_done_pulse: assert property (header_done |-> list_busy ##1 !header_done)
        else $error("bad header done pulse");
    a_reply_next: assert property (s_reply |-> ##2 (txn_start || header_done))
        else $error("no follow-up after reply");
    a_fields_hold: assert property (wt |-> $stable({txn_pid, txn_len, txn_toggle}))
        else $error("fields moved while waiting");
    a_single_txn: assert property (wt |-> !txn_start)
        else $error("second transaction started");
endmodule : uhd_host_descriptor_asserts

bind uhd_host_descriptor uhd_host_descriptor_asserts u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .txn_start, .txn_done,
    .txn_pid, .txn_len, .txn_toggle, .list_busy, .header_done
);

// ### uhd_txn_model.sv
`timescale 1ns/1ps
module uhd_txn_model (
    input  logic       pclk,
    input  logic       presetn,
    input  logic       txn_start,
    input  logic       txn_toggle,
    input  logic [9:0] txn_len,
    input  logic [7:0] err,
    input  logic [1:0] kind,
    output logic       txn_done,
    output logic [9:0] txn_count,
    output logic       txn_data_pid,
    output logic [7:0] flags
);
    logic       pend;
    logic [2:0] dly;
    // replies come promptly or late; outside a reply the data lines churn
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
            dly <= 3'h0;
            txn_done <= 1'b0;
            txn_count <= 10'h0;
            txn_data_pid <= 1'b0;
            flags <= 8'h0;
        end else begin
            txn_done <= 1'b0;
            flags <= 8'h0;
            txn_count <= ~txn_count;
            txn_data_pid <= ~txn_data_pid;
            if (txn_start) begin
                pend <= 1'b1;
                dly <= 3'($urandom % 5);
            end else if (pend && dly != 3'h0) begin
                dly <= dly - 3'h1;
            end else if (pend) begin
                pend <= 1'b0;
                txn_done <= 1'b1;
                flags <= err;
                txn_count <= (kind == 2'h2) ? txn_len + 10'h1 : (kind == 2'h3) ? txn_len - 10'h1 : txn_len;
                txn_data_pid <= txn_toggle ^ (kind == 2'h1);
            end
        end
    end
endmodule : uhd_txn_model

// ### uhd_host_descriptor_tb.sv
`timescale 1ns/1ps
module uhd_host_descriptor_tb;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdata, w0, w1, wb;
    logic        pready, pslverr, txn_start, txn_low_speed, txn_iso, txn_toggle;
    logic        list_busy, header_done, txn_done, txn_data_pid, t0, fm;
    logic [1:0]  txn_pid, kind = 2'h0;
    logic [6:0]  txn_addr;
    logic [3:0]  txn_endpoint;
    logic [9:0]  txn_len, txn_count, len, lim;
    logic [7:0]  fl, err = 8'h0;
    logic [64:0] q[$];
    logic [64:0] qv;
    int          mismatches = 0, cmp_count = 0, n;
    logic [15:0] tab [0:11] = '{16'h8058, 16'h4068, 16'h2078, 16'h1048, 16'h0818, 16'h0428,
                                16'h02c8, 16'h01d4, 16'h0039, 16'h008a, 16'h009b, 16'h007c};

    always #20 pclk = ~pclk;

    uhd_host_descriptor dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .txn_start, .txn_pid, .txn_addr, .txn_endpoint, .txn_low_speed, .txn_iso,
        .txn_toggle, .txn_len, .txn_done, .txn_count, .txn_data_pid, .txn_no_reply(fl[7]),
        .txn_pid_check_bad(fl[6]), .txn_pid_invalid(fl[5]), .txn_stall(fl[4]),
        .txn_crc_bad(fl[3]), .txn_stuff_bad(fl[2]), .txn_store_late(fl[1]),
        .txn_fetch_late(fl[0]), .list_busy, .header_done
    );
    uhd_txn_model u_far (
        .pclk, .presetn, .txn_start, .txn_toggle, .txn_len, .err, .kind, .txn_done,
        .txn_count, .txn_data_pid, .flags(fl)
    );

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // watcher: each completed transfer against the oldest note
    always @(negedge pclk) begin
        if (psel && penable && pready && q.size() > 0) begin
            qv = q.pop_front();
            check("pslverr", {31'h0, qv[64]}, {31'h0, pslverr});
            if (qv[63:32] != 32'h0)
                check("prdata", qv[31:0] & qv[63:32], prdata & qv[63:32]);
        end
    end

    // far-side request fields against the header that is running
    always @(negedge pclk) begin
        if (txn_start === 1'b1) begin
            check("txn_fields", {w1[23:16], w1[11:10], w0[31:28], w0[26]},
                  {txn_iso, txn_addr, txn_pid, txn_endpoint, txn_low_speed});
        end
    end

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, m, e, input logic se);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        q.push_back({se, m, e});
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdata = prdata;
        if (pready !== 1'b1) check("pready", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task walk;
        apb(1'b1, 12'h000, 32'h1, 32'h0, 32'h0, 1'b0);
        n = 0;
        do begin
            apb(1'b0, 12'h004, 32'h0, 32'h0, 32'h0, 1'b0);
            n++;
        end while (rdata[0] && n < 300);
        if (rdata[0]) check("list_busy", 32'h0, 32'h1);
    endtask : walk

    function automatic logic [31:0] hw0(input logic [9:0] lm, input logic lst, act, tg);
        return {4'h3, lst, tg, lm, 4'hf, act, tg, 10'h0};
    endfunction : hw0

    function automatic logic [31:0] hw1(input logic [9:0] ln, input logic [1:0] p);
        return {8'h0, 1'b0, 7'h05, 4'h0, p, ln};
    endfunction : hw1

    task give_verdict;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end

    initial begin
        n = $urandom(86948);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0, 32'h1ff, 32'h0, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'hffffffff, 32'h0, 1'b1);
        // one outcome per table row, at most one packet (none for the reserved pid)
        foreach (tab[i]) begin
            err <= tab[i][15:8];
            kind <= tab[i][1:0];
            w0 = hw0(10'h8, 1'b1, 1'b1, 1'b1);
            w1 = hw1(10'h8, tab[i][3:2]);
            apb(1'b1, 12'h800, w0, 32'h0, 32'h0, 1'b0);
            apb(1'b1, 12'h804, w1, 32'h0, 32'h0, 1'b0);
            walk();
            // a short packet is still a good packet: bytes count, toggle flips
            apb(1'b0, 12'h800, 32'h0, 32'hffffffff,
                {w0[31:16], tab[i][7:4], 1'b0, tab[i][1:0] != 2'h3, tab[i][1:0] == 2'h3 ? 10'h7 : 10'h0}, 1'b0);
        end
        err <= 8'h0;
        kind <= 2'h0;
        len = 10'(1 + $urandom % 60);
        lim = 10'(1 + $urandom % 16);
        t0 = 1'($urandom % 2);
        fm = 1'($urandom % 2);
        w0 = hw0(lim, 1'b1, 1'b1, t0);
        w1 = hw1(len, 2'($urandom % 3)) | {8'h00, fm, 23'h000000};
        apb(1'b1, 12'h800, w0, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h804, w1, 32'h0, 32'h0, 1'b0);
        walk();
        // isochronous moves one packet only and keeps its toggle
        n = (len + lim - 10'h1) / lim;
        apb(1'b0, 12'h800, 32'h0, 32'hffffffff,
            {w0[31:16], 4'h0, 1'b0, t0 ^ (n[0] & !fm), (fm && lim < len) ? lim : len}, 1'b0);
        // list: skipped entry, then last entry, then one past the end
        apb(1'b1, 12'h00c, 32'h0, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h008, 32'h4, 32'h0, 32'h0, 1'b0);
        w0 = hw0(10'h4, 1'b0, 1'b0, 1'b0);
        wb = hw0(10'h4, 1'b1, 1'b1, 1'b0);
        w1 = hw1(10'h4, 2'h1);
        apb(1'b1, 12'h810, w0, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h814, w1, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h81c, wb, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h820, w1, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h828, w0 | 32'h800, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 12'h82c, w1, 32'h0, 32'h0, 1'b0);
        walk();
        apb(1'b0, 12'h810, 32'h0, 32'hffffffff, w0, 1'b0);
        apb(1'b0, 12'h81c, 32'h0, 32'hffffffff, {wb[31:16], 4'h0, 1'b0, 1'b1, 10'h4}, 1'b0);
        apb(1'b0, 12'h828, 32'h0, 32'hffffffff, w0 | 32'h800, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 32'hffff, 32'h1, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 32'h1f1, 32'h100, 1'b0);
        give_verdict();
    end
endmodule : uhd_host_descriptor_tb
